// *** core/ies_event_status.sv ***
/*
  Event status logic: raw flags, masked status register, FIFO flush controls.
  Assumes controller events arrive as one-cycle pulses on clk_i, FIFO levels
  come from the FIFOs, and register accesses arrive as one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module ies_event_status #(
  parameter int DEPTH = ies_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration
  input wire logic enable_i,
  input wire logic internal_enable_signal_i,
  input wire logic sm_active_i,
  input wire logic [ies_pkg::STAT_W-1:0] mask_i,
  input wire logic [ies_pkg::LVL_W-1:0] tx_threshold_value_i,
  input wire logic [ies_pkg::LVL_W-1:0] rx_threshold_value_i,
  // Bus events
  input wire logic gen_call_ack_i,
  input wire logic start_seen_i,
  input wire logic stop_seen_i,
  input wire logic activity_i,
  input wire logic slv_tx_nack_i,
  input wire logic tx_abort_i,
  input wire logic [ies_pkg::ABRT_W-1:0] tx_abort_cause_i,
  input wire logic slv_read_req_i,
  input wire logic rx_byte_i,
  // FIFO levels and processor accesses
  input wire logic [ies_pkg::LVL_W-1:0] tx_level_i,
  input wire logic [ies_pkg::LVL_W-1:0] rx_level_i,
  input wire logic data_cmd_wr_i,
  input wire logic data_cmd_rd_i,
  input wire logic tx_data_wr_i,
  // Clear register reads
  input wire logic general_call_clear_reg_rd_i,
  input wire logic activity_clear_reg_rd_i,
  input wire logic combined_clear_reg_rd_i,
  input wire logic abort_clear_reg_rd_i,
  input wire logic read_request_clear_reg_rd_i,
  // Status register read port
  input wire logic stat_rd_i,
  input wire logic stat_wr_i,
  input wire logic [31:0] addr_i,
  output logic [31:0] rdata_o,
  // Outputs
  output logic [ies_pkg::STAT_W-1:0] raw_status_o,
  output logic [ies_pkg::ABRT_W-1:0] abort_cause_reg_o,
  output logic tx_flush_o,
  output logic rx_flush_o,
  output logic scl_hold_o,
  output logic rx_accept_o,
  output logic tx_push_o
);
  import ies_pkg::*;

  logic general_call_flag;
  logic start_seen_flag;
  logic stop_seen_flag;
  logic activity_flag;
  logic rx_done_flag;
  logic transmit_abort_flag;
  logic rd_req_flag;
  logic tx_over_q;
  logic rx_over_q;
  logic rx_under_q;
  logic tx_empty_lvl;
  logic rx_full_lvl;
  logic tx_full;
  logic rx_full;
  logic comb_clr;
  logic dis_clr;
  logic [STAT_W-1:0] masked_event_status;
  logic [ABRT_W-1:0] cause_q;

  assign comb_clr = combined_clear_reg_rd_i;
  assign dis_clr = !enable_i;
  assign tx_full = (tx_level_i >= LVL_W'(DEPTH));
  assign rx_full = (rx_level_i >= LVL_W'(DEPTH));

  // General call flag
  ies_sticky u_gen_call (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(gen_call_ack_i && enable_i),
    .clr_i(dis_clr || general_call_clear_reg_rd_i || comb_clr),
    .flag_o(general_call_flag)
  );
  // Start and stop flags
  ies_sticky u_start (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(start_seen_i),
    .clr_i(comb_clr),
    .flag_o(start_seen_flag)
  );
  ies_sticky u_stop (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(stop_seen_i),
    .clr_i(comb_clr),
    .flag_o(stop_seen_flag)
  );
  // Activity flag, cleared only by its three events
  ies_sticky u_act (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(activity_i && enable_i),
    .clr_i(dis_clr || activity_clear_reg_rd_i || comb_clr),
    .flag_o(activity_flag)
  );
  // Slave transmit done
  ies_sticky u_rx_done (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(slv_tx_nack_i),
    .clr_i(comb_clr),
    .flag_o(rx_done_flag)
  );
  // Transmit abort, released by its clear read or the combined clear read
  ies_sticky u_abrt (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(tx_abort_i),
    .clr_i(abort_clear_reg_rd_i || comb_clr),
    .flag_o(transmit_abort_flag)
  );
  // Read request flag
  ies_sticky u_rd_req (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .set_i(slv_read_req_i),
    .clr_i(read_request_clear_reg_rd_i || comb_clr),
    .flag_o(rd_req_flag)
  );

  // Abort cause capture
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cause_q <= '0;
    end else if (tx_abort_i) begin
      cause_q <= tx_abort_cause_i;
    end else if (abort_clear_reg_rd_i || comb_clr) begin
      cause_q <= '0;
    end
  end

  // Overflow and underflow flags, held until internal enable drops or a combined clear read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_over_q <= 1'b0;
    end else if (data_cmd_wr_i && tx_full) begin
      tx_over_q <= 1'b1;
    end else if (!internal_enable_signal_i || comb_clr) begin
      tx_over_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_over_q <= 1'b0;
    end else if (rx_byte_i && rx_full) begin
      rx_over_q <= 1'b1;
    end else if (!internal_enable_signal_i || comb_clr) begin
      rx_over_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_under_q <= 1'b0;
    end else if (data_cmd_rd_i && (rx_level_i == '0)) begin
      rx_under_q <= 1'b1;
    end else if (!internal_enable_signal_i || comb_clr) begin
      rx_under_q <= 1'b0;
    end
  end

  // Level flags follow FIFO levels while enabled
  always_comb begin
    if (enable_i) begin
      tx_empty_lvl = (tx_level_i <= tx_threshold_value_i);
    end else begin
      tx_empty_lvl = sm_active_i;
    end
    rx_full_lvl = enable_i && (rx_level_i >= rx_threshold_value_i);
  end

  // FIFO controls
  assign tx_flush_o = transmit_abort_flag || !enable_i;
  assign rx_flush_o = !enable_i;
  assign tx_push_o = tx_data_wr_i && !tx_flush_o && !tx_full;
  assign rx_accept_o = rx_byte_i && !rx_full && enable_i;
  assign scl_hold_o = rd_req_flag;
  assign abort_cause_reg_o = cause_q;

  // Raw status assembly
  always_comb begin
    raw_status_o = STAT_RST;
    raw_status_o[BIT_GEN_CALL] = general_call_flag;
    raw_status_o[BIT_START] = start_seen_flag;
    raw_status_o[BIT_STOP] = stop_seen_flag;
    raw_status_o[BIT_ACT] = activity_flag;
    raw_status_o[BIT_RX_DONE] = rx_done_flag;
    raw_status_o[BIT_TX_ABRT] = transmit_abort_flag;
    raw_status_o[BIT_RD_REQ] = rd_req_flag;
    raw_status_o[BIT_TX_EMPTY] = tx_empty_lvl;
    raw_status_o[BIT_TX_OVER] = tx_over_q;
    raw_status_o[BIT_RX_FULL] = rx_full_lvl;
    raw_status_o[BIT_RX_OVER] = rx_over_q;
    raw_status_o[BIT_RX_UNDER] = rx_under_q;
  end

  // Masked view, upper bits forced zero
  assign masked_event_status = raw_status_o & mask_i & 16'h0FFF;

  // Read data register; writes are ignored
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (stat_rd_i && (addr_i == STAT_OFFSET)) begin
      rdata_o <= {16'h0000, masked_event_status};
    end else begin
      rdata_o <= '0;
    end
  end

  // Assertions
  property p_gen_call_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    (gen_call_ack_i && enable_i) |=> general_call_flag;
  endproperty
  a_gen_call_set: assert property (p_gen_call_set) else $error("gen call not set");

  property p_gen_call_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!enable_i && !gen_call_ack_i) |=> !general_call_flag;
  endproperty
  a_gen_call_clr: assert property (p_gen_call_clr) else $error("gen call not cleared");

  property p_act_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    (activity_flag && enable_i && !activity_clear_reg_rd_i && !comb_clr) |=> activity_flag;
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("activity dropped");

  property p_abrt_flush;
    @(posedge clk_i) disable iff (!rst_b_i)
    tx_abort_i |=> (tx_flush_o && !tx_push_o);
  endproperty
  a_abrt_flush: assert property (p_abrt_flush) else $error("no flush on abort");

  property p_rd_req_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
    (read_request_clear_reg_rd_i && !slv_read_req_i) |=> !scl_hold_o;
  endproperty
  a_rd_req_clr: assert property (p_rd_req_clr) else $error("rd req not cleared");

  property p_tx_over;
    @(posedge clk_i) disable iff (!rst_b_i)
    (data_cmd_wr_i && tx_level_i == LVL_W'(DEPTH)) |=> raw_status_o[BIT_TX_OVER];
  endproperty
  a_tx_over: assert property (p_tx_over) else $error("tx over missed");

  property p_rx_dis;
    @(posedge clk_i) disable iff (!rst_b_i)
    $fell(enable_i) |-> (!raw_status_o[BIT_RX_FULL] && rx_flush_o);
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("rx full not cleared");

  property p_rx_drop;
    @(posedge clk_i) disable iff (!rst_b_i)
    (rx_byte_i && rx_level_i == LVL_W'(DEPTH)) |-> (!rx_accept_o ##1 raw_status_o[BIT_RX_OVER]);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("overflow byte kept");

  property p_under;
    @(posedge clk_i) disable iff (!rst_b_i)
    (data_cmd_rd_i && rx_level_i == '0) |=> raw_status_o[BIT_RX_UNDER];
  endproperty
  a_under: assert property (p_under) else $error("underflow missed");

  property p_upper;
    @(posedge clk_i) disable iff (!rst_b_i)
    stat_rd_i |=> (rdata_o[31:12] == 20'h00000);
  endproperty
  a_upper: assert property (p_upper) else $error("reserved bits set");

  property p_start_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    start_seen_i |=> raw_status_o[BIT_START];
  endproperty
  a_start_set: assert property (p_start_set) else $error("start not set");

  property p_stop_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    stop_seen_i |=> raw_status_o[BIT_STOP];
  endproperty
  a_stop_set: assert property (p_stop_set) else $error("stop not set");

  property p_act_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    (activity_i && enable_i) |=> raw_status_o[BIT_ACT];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activity not set");

  property p_nack_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    slv_tx_nack_i |=> raw_status_o[BIT_RX_DONE];
  endproperty
  a_nack_set: assert property (p_nack_set) else $error("transmit done not set");

  property p_abrt_cause;
    @(posedge clk_i) disable iff (!rst_b_i)
    tx_abort_i |=> (abort_cause_reg_o == $past(tx_abort_cause_i));
  endproperty
  a_abrt_cause: assert property (p_abrt_cause) else $error("abort cause not kept");

  property p_push_flush;
    @(posedge clk_i) disable iff (!rst_b_i)
    tx_flush_o |-> !tx_push_o;
  endproperty
  a_push_flush: assert property (p_push_flush) else $error("push while flushed");

  property p_rd_req_set;
    @(posedge clk_i) disable iff (!rst_b_i)
    slv_read_req_i |=> (raw_status_o[BIT_RD_REQ] && scl_hold_o);
  endproperty
  a_rd_req_set: assert property (p_rd_req_set) else $error("rd req not held");

  property p_tx_empty;
    @(posedge clk_i) disable iff (!rst_b_i)
    enable_i |-> (raw_status_o[BIT_TX_EMPTY] == (tx_level_i <= tx_threshold_value_i));
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty wrong");

  property p_tx_dis;
    @(posedge clk_i) disable iff (!rst_b_i)
    !enable_i |-> (tx_flush_o && (raw_status_o[BIT_TX_EMPTY] == sm_active_i));
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("tx empty wrong when disabled");

  property p_rx_over_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!internal_enable_signal_i && !(rx_byte_i && rx_full)) |=> !raw_status_o[BIT_RX_OVER];
  endproperty
  a_rx_over_clr: assert property (p_rx_over_clr) else $error("rx over not cleared");

  property p_rx_full;
    @(posedge clk_i) disable iff (!rst_b_i)
    enable_i |-> (raw_status_o[BIT_RX_FULL] == (rx_level_i >= rx_threshold_value_i));
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full wrong");

  property p_mask;
    @(posedge clk_i) disable iff (!rst_b_i)
    (stat_rd_i && (addr_i == STAT_OFFSET)) |=> (rdata_o == {16'h0000, $past(raw_status_o) & $past(mask_i) & 16'h0FFF});
  endproperty
  a_mask: assert property (p_mask) else $error("masked status wrong");

  property p_wr_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
    (stat_wr_i && !stat_rd_i) |=> (rdata_o == 32'h00000000);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("status write took effect");
endmodule : ies_event_status
`default_nettype wire

// *** core/ies_pkg.sv ***
/*
  Constants for the two-wire controller event status block.
  Assumes: one clock, levels and events come from the same clock domain.
*/
`default_nettype none
package ies_pkg;
  localparam logic [31:0] STAT_OFFSET = 32'h5000132C;
  localparam int STAT_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W = 6;
  localparam int ABRT_W = 16;
  localparam int BIT_GEN_CALL = 11;
  localparam int BIT_START = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_ACT = 8;
  localparam int BIT_RX_DONE = 7;
  localparam int BIT_TX_ABRT = 6;
  localparam int BIT_RD_REQ = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_TX_OVER = 3;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_RX_OVER = 1;
  localparam int BIT_RX_UNDER = 0;
  localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;
  localparam logic [STAT_W-1:0] MASK_RST = 16'h08FF;
endpackage : ies_pkg
`default_nettype wire

// *** core/ies_sticky.sv ***
/*
  One sticky flag: set wins over clear.
  Assumes same-clock set and clear pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ies_sticky (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  // Set has priority over clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule : ies_sticky
`default_nettype wire

// *** testbench/ies_remote_bus.sv ***
/*
  Remote two-wire bus model: random bus events as one-cycle pulses.
  Assumes scl_hold_i is the clock stretch from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module ies_remote_bus #(
  parameter int SEED = 1
) (
  // Clock and stretch
  input wire logic clk_i,
  input wire logic scl_hold_i,
  // Event pulses
  output logic [7:0] ev_o
);
  int seed = SEED;
  int r;
  // New events after each edge, none while the clock is held low
  always @(posedge clk_i) begin
    #1;
    r = $random(seed);
    ev_o = scl_hold_i ? 8'h00 : (r[7:0] & r[15:8] & r[23:16]);
  end
endmodule : ies_remote_bus
`default_nettype wire

// *** testbench/tb_ies_event_status.sv ***
/*
  Random bench for the event status block against a reference model.
  Assumes the remote bus model drives the event pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_ies_event_status;
  import ies_pkg::*;
  logic clk = 0, rst_b = 0, en = 0, sm = 0, dwr = 0, drd = 0, twr = 0, srd = 0, swr = 0;
  logic [4:0] clr = 0;
  logic [15:0] mask = 0, cause = 0, sf = 0, mc = 0, raw, acr;
  logic [5:0] txt = 0, rxt = 0, txl = 0, rxl = 0;
  logic [31:0] addr = 0, mrd = 0, rdata;
  logic txf, rxf, hold, acc, push;
  logic [7:0] ev;
  int seed = 16773, errors = 0, n_compared = 0, r;

  always #2 clk = ~clk;

  ies_remote_bus #(.SEED(5)) ies_remote_bus_i (.clk_i(clk), .scl_hold_i(hold), .ev_o(ev));
  ies_event_status #(.DEPTH(32)) ies_event_status_i (.clk_i(clk), .rst_b_i(rst_b), .enable_i(en),
    .internal_enable_signal_i(en), .sm_active_i(sm), .mask_i(mask), .tx_threshold_value_i(txt),
    .rx_threshold_value_i(rxt), .gen_call_ack_i(ev[0]), .start_seen_i(ev[1]), .stop_seen_i(ev[2]),
    .activity_i(ev[3]), .slv_tx_nack_i(ev[4]), .tx_abort_i(ev[5]), .tx_abort_cause_i(cause),
    .slv_read_req_i(ev[6]), .rx_byte_i(ev[7]), .tx_level_i(txl), .rx_level_i(rxl), .data_cmd_wr_i(dwr),
    .data_cmd_rd_i(drd), .tx_data_wr_i(twr), .general_call_clear_reg_rd_i(clr[0]),
    .activity_clear_reg_rd_i(clr[1]), .combined_clear_reg_rd_i(clr[2]), .abort_clear_reg_rd_i(clr[3]),
    .read_request_clear_reg_rd_i(clr[4]), .stat_rd_i(srd), .stat_wr_i(swr), .addr_i(addr), .rdata_o(rdata),
    .raw_status_o(raw), .abort_cause_reg_o(acr), .tx_flush_o(txf), .rx_flush_o(rxf), .scl_hold_o(hold),
    .rx_accept_o(acc), .tx_push_o(push));

  // Model status: sticky flags plus the two level bits
  function automatic logic [15:0] mraw();
    mraw = sf;
    mraw[4] = en ? (txl <= txt) : sm;
    mraw[2] = en && (rxl >= rxt);
  endfunction : mraw

  // Model update on each edge, set wins over clear
  always @(posedge clk or negedge rst_b) begin
    logic [15:0] s, c;
    if (!rst_b) begin
      sf = 0;
      mc = 0;
      mrd = 0;
    end else begin
      s = {4'h0, ev[0] && en, ev[1], ev[2], ev[3] && en, ev[4], ev[5], ev[6], 1'b0, dwr && txl >= 32, 1'b0,
           ev[7] && rxl >= 32, drd && rxl == 0};
      c = {16{clr[2]}};
      c[11] |= clr[0] | !en;
      c[8] |= clr[1] | !en;
      c[6] |= clr[3];
      c[5] |= clr[4];
      c[3] |= !en;
      c[1] |= !en;
      c[0] |= !en;
      mrd = (srd && addr == STAT_OFFSET) ? {16'h0000, mraw() & mask} : 32'h0;
      if (ev[5])
        mc = cause;
      else if (clr[3] || clr[2])
        mc = 0;
      sf = (sf & ~c) | s;
    end
  end

  // Compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  // Verdict and end of run
  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Reset, then random traffic checked every cycle
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk("reset rdata", 32'h0, rdata);
    rst_b = 1;
    for (int k = 0; k < 6000; k++) begin
      @(posedge clk);
      #0.5;
      chk("raw_status", {16'h0, mraw()}, {16'h0, raw});
      chk("rdata", mrd, rdata);
      chk("abort_cause", {16'h0, mc}, {16'h0, acr});
      chk("tx_flush", sf[6] | !en, txf);
      chk("rx_flush", !en, rxf);
      chk("scl_hold", sf[5], hold);
      chk("rx_accept", en && ev[7] && rxl < 32, acc);
      chk("tx_push", twr && !(sf[6] | !en) && txl < 32, push);
      #0.5;
      r = $random(seed);
      en = (k % 512) < 480;
      sm = r[0];
      txl = r[6:1] > 32 ? 6'h20 : r[6:1];
      rxl = r[12:7] > 32 ? 6'h00 : r[12:7];
      dwr = (r[13] & r[14]) | (hold & r[13]);
      drd = r[15] & r[16];
      twr = r[17];
      clr = r[22:18] & r[27:23] & {5{r[28]}};
      srd = r[29];
      swr = r[30];
      addr = STAT_OFFSET + {r[31], 2'b00};
      r = $random(seed);
      cause = r[15:0];
      if (k % 64 == 0)
        {mask, txt, rxt} = {r[31:16], r[5:0], r[11:6]};
    end
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #30000;
    errors++;
    summarize();
  end
endmodule : tb_ies_event_status
`default_nettype wire
